// File: two_phase_micro_sequencer_pkg.sv
/*
  Shared constants and types for the two-phase micro sequencer: timing counts,
  op codes, operand source codes, register map and the packed state record.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
*/
package two_phase_micro_sequencer_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 200;
  localparam int PULSE_NS = 70;
  localparam int INSTR_NS = 400;
  localparam int PHASE_CYC = (INSTR_NS / 2) / CLK_PERIOD_NS;
  localparam int OSC_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STRB_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] CNT_LAST = 5'(OSC_CYC - 1);
  localparam logic [4:0] STRB_FIRST = 5'(PHASE_CYC - STRB_CYC);

  localparam int DATA_W = 12;
  localparam int ROM_DEPTH = 1024;
  localparam int GR_COUNT = 16;

  localparam logic [3:0] OP_CPR = 4'h0;
  localparam logic [3:0] OP_ADD = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_AND = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_DEC = 4'h5;
  localparam logic [3:0] OP_INC = 4'h6;
  localparam logic [3:0] OP_MOV = 4'h7;
  localparam logic [3:0] OP_CPL = 4'h8;
  localparam logic [3:0] OP_XOR = 4'h9;
  localparam logic [3:0] OP_BR = 4'hA;
  localparam logic [3:0] OP_SPC = 4'hB;
  localparam logic [1:0] OP_LDZ_TOP = 2'h3;

  localparam logic [3:0] SRC_SWITCH_A = 4'hA;
  localparam logic [3:0] SRC_SWITCH_B = 4'hB;

  localparam logic [7:0] SPC_DIS_A_BANK = 8'h12;
  localparam logic [7:0] SPC_EN_A_BANK = 8'h13;
  localparam logic [7:0] SPC_DIS_B_BANK = 8'h14;
  localparam logic [7:0] SPC_EN_B_BANK = 8'h15;

  localparam logic [2:0] BRQ_ALWAYS = 3'h0;
  localparam logic [2:0] BRQ_ZERO = 3'h1;
  localparam logic [2:0] BRQ_NOT_ZERO = 3'h2;
  localparam logic [2:0] BRQ_MINUS = 3'h3;

  localparam logic [15:0] ADR_CTRL = 16'h0000;
  localparam logic [15:0] ADR_STATUS = 16'h0004;
  localparam logic [15:0] ADR_PC = 16'h0008;
  localparam logic [15:0] ADR_OUT = 16'h000C;
  localparam logic [15:0] ADR_TEMP = 16'h0010;
  localparam logic [15:0] ADR_IR = 16'h0014;
  localparam logic [15:0] ADR_GR_BASE = 16'h0800;
  localparam logic [15:0] ADR_ROM_BASE = 16'h1000;
  localparam int CTRL_RUN_BIT = 0;
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_MINUS_BIT = 1;
  localparam int ST_PHASE_B_BIT = 2;
  localparam int ST_BANK_A_BIT = 3;
  localparam int ST_BANK_B_BIT = 4;
  localparam int ST_RUN_BIT = 5;

  typedef enum logic [1:0] {
    PH_A = 2'b01,
    PH_B = 2'b10
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [4:0] cnt;
    logic run;
    logic [11:0] pc;
    logic [11:0] ir;
    logic [11:0] temp;
    logic zero_pend;
    logic zero;
    logic minus;
    logic bank_a;
    logic bank_b;
    logic [GR_COUNT-1:0][11:0] gr;
    logic [11:0] out_data;
    logic [2:0] out_sel;
    logic out_stb;
    logic strb_a;
    logic strb_b;
    logic ack;
    logic [31:0] rdata;
  } seq_state_s;
endpackage : two_phase_micro_sequencer_pkg

// File: two_phase_micro_sequencer.sv
/*
  Two-phase instruction sequencer and decoder with its program memory,
  sixteen general registers, temporary register, ALU and condition flags.
  Assumes one 100 MHz clock, synchronous active-high reset and a classic
  Wishbone master that loads the program while the sequencer is halted.
*/
`timescale 1ns/10ps
module two_phase_micro_sequencer #(
  parameter int ROM_WORDS = two_phase_micro_sequencer_pkg::ROM_DEPTH
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic SRST_I,
  // Wishbone slave.
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [15:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Operand sources outside the register file.
  input wire logic [two_phase_micro_sequencer_pkg::DATA_W-1:0] SW_A_I,
  input wire logic [two_phase_micro_sequencer_pkg::DATA_W-1:0] SW_B_I,
  input wire logic [two_phase_micro_sequencer_pkg::DATA_W-1:0] AUX_I,
  // Timing and state.
  output logic PHASE_B_O,
  output logic STRB_A_O,
  output logic STRB_B_O,
  output logic [11:0] PC_O,
  output logic ZERO_O,
  output logic MINUS_O,
  // Output register destination.
  output logic [two_phase_micro_sequencer_pkg::DATA_W-1:0] OUT_DATA_O,
  output logic [2:0] OUT_SEL_O,
  output logic OUT_STB_O
);
  import two_phase_micro_sequencer_pkg::*;

  seq_state_s st_ff;
  seq_state_s nxt_st;
  logic [11:0] rom_mem [ROM_WORDS];

  // Register bank select: the bank flag replaces bit 3 of a register code.
  function automatic logic [11:0] gr_read(input seq_state_s s, input logic bank, input logic [2:0] idx);
    gr_read = s.gr[{bank, idx}];
  endfunction : gr_read

  // Operand source decode for the first field.
  function automatic logic [11:0] src_read(input seq_state_s s, input logic [3:0] code,
                                           input logic [11:0] sw_a, input logic [11:0] sw_b,
                                           input logic [11:0] aux);
    if (!code[3]) begin
      src_read = gr_read(s, s.bank_a, code[2:0]);
    end else if (code == SRC_SWITCH_A) begin
      src_read = sw_a;
    end else if (code == SRC_SWITCH_B) begin
      src_read = sw_b;
    end else begin
      src_read = aux;
    end
  endfunction : src_read

  logic wb_req;
  logic wb_wr;
  logic [11:0] rom_word;
  logic [3:0] opcode;
  logic is_ldz;
  logic [11:0] b_bus;
  logic [11:0] a_true;
  logic [11:0] a_bus_n;
  logic [11:0] c_bus_n;
  logic [11:0] alu_out;
  logic end_a;
  logic end_b;
  logic strb_b_lead;
  logic br_take;
  logic writes_dest;

  assign wb_req = CYC_I & STB_I & ~st_ff.ack;
  assign wb_wr = wb_req & WE_I;
  assign rom_word = rom_mem[st_ff.pc[$clog2(ROM_WORDS)-1:0]];

  assign opcode = st_ff.ir[11:8];
  assign is_ldz = (st_ff.ir[11:10] == OP_LDZ_TOP);

  assign a_true = st_ff.temp;
  assign a_bus_n = ~st_ff.temp;

  assign end_a = st_ff.run && (st_ff.phase == PH_A) && (st_ff.cnt == CNT_LAST);
  assign end_b = st_ff.run && (st_ff.phase == PH_B) && (st_ff.cnt == CNT_LAST);
  assign strb_b_lead = st_ff.run && (st_ff.phase == PH_B) && (st_ff.cnt == STRB_FIRST);

  // destination write except compare, branch and special control.
  assign writes_dest = is_ldz || !(opcode == OP_CPR || opcode == OP_BR || opcode == OP_SPC);

  always_comb begin
    b_bus = 12'h000;
    alu_out = 12'h000;
    if (st_ff.phase == PH_A) begin
      b_bus = src_read(st_ff, st_ff.ir[7:4], SW_A_I, SW_B_I, AUX_I);
      alu_out = b_bus;
    end else begin
      if (is_ldz) begin
        b_bus = {2'b00, st_ff.ir[9:0]};
      end else if (opcode <= OP_AND || opcode == OP_OR || opcode == OP_XOR) begin
        // second operand from B register bank choice.
        b_bus = gr_read(st_ff, st_ff.bank_b, st_ff.ir[2:0]);
      end
      if (is_ldz) begin
        alu_out = b_bus;
      end else begin
        case (opcode)
          OP_CPR, OP_SUB: alu_out = 12'(~a_bus_n - b_bus);
          OP_ADD: alu_out = 12'(~a_bus_n + b_bus);
          OP_AND: alu_out = ~a_bus_n & b_bus;
          OP_OR: alu_out = ~a_bus_n | b_bus;
          OP_DEC: alu_out = 12'(~a_bus_n - 12'h001);
          OP_INC: alu_out = 12'(~a_bus_n + 12'h001);
          OP_CPL: alu_out = a_bus_n;
          OP_XOR: alu_out = ~a_bus_n ^ b_bus;
          default: alu_out = ~a_bus_n;
        endcase
      end
    end
    c_bus_n = ~alu_out;
  end

  always_comb begin
    case (st_ff.ir[2:0])
      BRQ_ALWAYS: br_take = 1'b1;
      BRQ_ZERO: br_take = st_ff.zero;
      BRQ_NOT_ZERO: br_take = ~st_ff.zero;
      BRQ_MINUS: br_take = st_ff.minus;
      default: br_take = 1'b0;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.out_stb = 1'b0;
    nxt_st.ack = wb_req;
    if (wb_wr && ADR_I == ADR_CTRL && SEL_I[0]) begin
      nxt_st.run = DAT_I[CTRL_RUN_BIT];
    end
    if (wb_req) begin
      if (ADR_I == ADR_CTRL) begin
        nxt_st.rdata = 32'({st_ff.run});
      end else if (ADR_I == ADR_STATUS) begin
        nxt_st.rdata = 32'({st_ff.run, st_ff.bank_b, st_ff.bank_a, (st_ff.phase == PH_B), st_ff.minus, st_ff.zero});
      end else if (ADR_I == ADR_PC) begin
        nxt_st.rdata = 32'(st_ff.pc);
      end else if (ADR_I == ADR_OUT) begin
        nxt_st.rdata = 32'(st_ff.out_data);
      end else if (ADR_I == ADR_TEMP) begin
        nxt_st.rdata = 32'(st_ff.temp);
      end else if (ADR_I == ADR_IR) begin
        nxt_st.rdata = 32'(st_ff.ir);
      end else if (ADR_I[15:6] == ADR_GR_BASE[15:6]) begin
        nxt_st.rdata = 32'(st_ff.gr[ADR_I[5:2]]);
      end else if (ADR_I[15:12] == ADR_ROM_BASE[15:12]) begin
        nxt_st.rdata = 32'(rom_mem[ADR_I[$clog2(ROM_WORDS)+1:2]]);
      end else begin
        nxt_st.rdata = 32'h0000_0000;
      end
    end

    if (!st_ff.run) begin
      // Halted: timing held at the start of a first phase, next word prefetched.
      nxt_st.phase = PH_A;
      nxt_st.cnt = 5'h00;
      nxt_st.ir = rom_word;
    end else begin
      if (st_ff.cnt == CNT_LAST) begin
        nxt_st.cnt = 5'h00;
        nxt_st.phase = (st_ff.phase == PH_A) ? PH_B : PH_A;
      end else begin
        nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
      end
      if (st_ff.phase == PH_A && st_ff.cnt == STRB_FIRST) begin
        nxt_st.temp = ~c_bus_n;
      end
      if (strb_b_lead) begin
        nxt_st.temp = ~c_bus_n;
        nxt_st.zero_pend = &c_bus_n;
      end
      if (end_a) begin
        nxt_st.pc = 12'(st_ff.pc + 12'h001);
      end
      if (end_b) begin
        nxt_st.zero = st_ff.zero_pend;
        nxt_st.minus = a_true[11] & ~st_ff.zero_pend;
        nxt_st.ir = rom_word;
        if (!is_ldz && opcode == OP_BR && br_take) begin
          nxt_st.pc = a_true;
          nxt_st.ir = rom_mem[a_true[$clog2(ROM_WORDS)-1:0]];
        end
        if (!is_ldz && opcode == OP_SPC) begin
          case (st_ff.ir[7:0])
            SPC_DIS_A_BANK: nxt_st.bank_a = 1'b0;
            SPC_EN_A_BANK: nxt_st.bank_a = 1'b1;
            SPC_DIS_B_BANK: nxt_st.bank_b = 1'b0;
            SPC_EN_B_BANK: nxt_st.bank_b = 1'b1;
            default: nxt_st.bank_b = st_ff.bank_b;
          endcase
        end
        if (is_ldz) begin
          nxt_st.gr[0] = ~a_bus_n;
        end else if (writes_dest) begin
          // final destination from inverted feedback bus.
          if (!st_ff.ir[3]) begin
            nxt_st.gr[{st_ff.bank_b, st_ff.ir[2:0]}] = ~a_bus_n;
          end else begin
            nxt_st.out_data = a_true;
            nxt_st.out_sel = st_ff.ir[2:0];
            nxt_st.out_stb = 1'b1;
          end
        end
      end
    end
    // strobes during last part of each phase.
    nxt_st.strb_a = nxt_st.run && (nxt_st.phase == PH_A) && (nxt_st.cnt >= STRB_FIRST);
    nxt_st.strb_b = nxt_st.run && (nxt_st.phase == PH_B) && (nxt_st.cnt >= STRB_FIRST);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      // reset to first phase, counter and flags clear.
      st_ff <= '0;
      st_ff.phase <= PH_A;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // program memory written over the bus.
  always_ff @(posedge CLK_I) begin
    if (wb_wr && ADR_I[15:12] == ADR_ROM_BASE[15:12] && (&SEL_I[1:0])) begin
      rom_mem[ADR_I[$clog2(ROM_WORDS)+1:2]] <= DAT_I[11:0];
    end
  end

  assign DAT_O = st_ff.rdata;
  assign ACK_O = st_ff.ack;
  assign PHASE_B_O = (st_ff.phase == PH_B);
  assign STRB_A_O = st_ff.strb_a;
  assign STRB_B_O = st_ff.strb_b;
  assign PC_O = st_ff.pc;
  assign ZERO_O = st_ff.zero;
  assign MINUS_O = st_ff.minus;
  assign OUT_DATA_O = st_ff.out_data;
  assign OUT_SEL_O = st_ff.out_sel;
  assign OUT_STB_O = st_ff.out_stb;
endmodule : two_phase_micro_sequencer

// File: front_panel_model.sv
/*
  Front panel switch rows and auxiliary source that feed the operand inputs.
  Assumes the bench sets the switch pattern between instructions.
*/
`timescale 1ns/10ps
module front_panel_model (
  // Switch pattern chosen by the bench.
  input wire logic [11:0] set_i,
  // Operand sources.
  output logic [11:0] sw_a_o,
  output logic [11:0] sw_b_o,
  output logic [11:0] aux_o
);
  // The rows differ so that a wrong source selection shows in the result.
  assign sw_a_o = set_i;
  assign sw_b_o = ~set_i;
  assign aux_o = {set_i[5:0], set_i[11:6]};
endmodule : front_panel_model

// File: two_phase_micro_sequencer_sva.sv
/*
  Checker for strobe, phase, flag and bus timing at the sequencer ports.
  Assumes one clock and the synchronous active-high reset of the design.
*/
`timescale 1ns/10ps
module seq_sva (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic SRST_I,
  // Bus handshake.
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  // Sequencer outputs.
  input wire logic PHASE_B_O,
  input wire logic STRB_A_O,
  input wire logic STRB_B_O,
  input wire logic [11:0] PC_O,
  input wire logic ZERO_O,
  input wire logic MINUS_O,
  input wire logic OUT_STB_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  strb_a_len_a: assert property ($rose(STRB_A_O) |-> STRB_A_O[*7] ##1 !STRB_A_O)
    else $error("first strobe width wrong");
  strb_b_len_a: assert property ($rose(STRB_B_O) |-> STRB_B_O[*7] ##1 !STRB_B_O)
    else $error("second strobe width wrong");
  strb_phase_a: assert property ((STRB_A_O |-> !PHASE_B_O) and (STRB_B_O |-> PHASE_B_O))
    else $error("strobe outside its phase");
  osc_period_a: assert property ($rose(STRB_A_O) |-> ##20 $rose(STRB_B_O))
    else $error("strobe spacing wrong");
  phase_len_a: assert property ($rose(PHASE_B_O) |-> ##20 $fell(PHASE_B_O))
    else $error("second phase length wrong");
  pc_adv_a: assert property ($rose(PHASE_B_O) |-> PC_O == $past(PC_O) + 12'h001)
    else $error("counter not advanced at phase end");
  out_stb_a: assert property (OUT_STB_O |-> $fell(PHASE_B_O) ##1 !OUT_STB_O)
    else $error("output strobe misplaced");
  flag_excl_a: assert property (!(ZERO_O && MINUS_O))
    else $error("both flags set");
  flag_time_a: assert property (($changed(ZERO_O) || $changed(MINUS_O)) |-> $fell(PHASE_B_O))
    else $error("flags changed mid instruction");
  bus_ack_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("bus answer timing wrong");
  cover property ($rose(STRB_B_O));
  cover property (OUT_STB_O);
  cover property (ZERO_O);
  cover property (MINUS_O);
endmodule : seq_sva

bind two_phase_micro_sequencer seq_sva u_sva (.CLK_I, .SRST_I, .CYC_I, .STB_I, .ACK_O, .PHASE_B_O,
  .STRB_A_O, .STRB_B_O, .PC_O, .ZERO_O, .MINUS_O, .OUT_STB_O);

// File: two_phase_micro_sequencer_tb_top.sv
/*
  Self-checking bench: loads a program over the bus, runs it, checks results.
  Assumes the front panel model drives the operand source inputs.
*/
`timescale 1ns/10ps
module two_phase_micro_sequencer_tb_top;
  import two_phase_micro_sequencer_pkg::*;
  logic CLK_I = 0, SRST_I = 1, CYC_I = 0, STB_I = 0, WE_I = 0;
  logic [15:0] ADR_I = 16'h0000;
  logic [3:0] SEL_I = 4'hF;
  logic [31:0] DAT_I = 32'h0, DAT_O, q;
  logic ACK_O, PHASE_B_O, STRB_A_O, STRB_B_O, ZERO_O, MINUS_O, OUT_STB_O;
  logic [11:0] SW_A_I, SW_B_I, AUX_I, PC_O, OUT_DATA_O, pan = 12'h000, v, g, e, sa;
  logic [2:0] OUT_SEL_O;
  logic [3:0] ops [10];
  logic [11:0] tail [7];
  int num_errors = 0, check_count = 0, n_out = 0, seed = 70;
  two_phase_micro_sequencer dut (.CLK_I, .SRST_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O,
    .SW_A_I, .SW_B_I, .AUX_I, .PHASE_B_O, .STRB_A_O, .STRB_B_O, .PC_O, .ZERO_O, .MINUS_O, .OUT_DATA_O,
    .OUT_SEL_O, .OUT_STB_O);
  front_panel_model panel (.set_i(pan), .sw_a_o(SW_A_I), .sw_b_o(SW_B_I), .aux_o(AUX_I));
  initial begin
    forever #5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    if (OUT_STB_O === 1'b1) n_out <= n_out + 1;
  end
  function automatic logic [11:0] alu(input logic [3:0] op, input logic [11:0] a, input logic [11:0] b);
    case (op)
      OP_ADD: return a + b;
      OP_SUB, OP_CPR: return a - b;
      OP_AND: return a & b;
      OP_OR: return a | b;
      OP_DEC: return a - 12'h001;
      OP_INC: return a + 12'h001;
      OP_CPL: return ~a;
      OP_XOR: return a ^ b;
      default: return a;
    endcase
  endfunction : alu
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= d;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wb
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic wait_ph(input logic val);
    int n;
    n = 0;
    while (PHASE_B_O !== val) begin
      @(posedge CLK_I);
      #1;
      n++;
      if (n > 60) begin
        num_errors++;
        tally_and_finish();
      end
    end
  endtask : wait_ph
  task automatic step();
    wait_ph(1'b1);
    wait_ph(1'b0);
  endtask : step
  task automatic fl(input logic [11:0] r);
    chk(32'({MINUS_O, ZERO_O}), 32'({r[11] & (|r), ~(|r)}));
  endtask : fl
  task automatic do_reset();
    SRST_I <= 1'b1;
    repeat (20) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    #1;
    chk(32'({PC_O, ZERO_O, MINUS_O, PHASE_B_O}), 32'h0);
  endtask : do_reset
  initial begin
    ops = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_DEC, OP_INC, OP_MOV, OP_CPL, OP_XOR, OP_CPR};
    // The last word branches on zero, which the immediate load of zero has just set.
    tail = '{12'h718, 12'hB15, 12'h702, 12'hB13, 12'h723, 12'hC00, 12'hA01};
    g = 12'($random(seed));
    sa = 12'($random(seed));
    v = {2'b00, g[9:0]};
    do_reset();
    @(posedge CLK_I);
    pan <= sa;
    rd(16'h0040, 32'h0);
    // Bits 11 and 10 carry the immediate-load code; only random bits 9 to 0 reach the loaded value.
    wb(1'b1, ADR_ROM_BASE, {20'h0, 2'b11, g[9:0]});
    wb(1'b1, ADR_ROM_BASE + 16'h0004, 32'h701);
    for (int i = 0; i < 10; i++) wb(1'b1, ADR_ROM_BASE + 16'(8 + 4 * i), {20'h0, ops[i], 8'hA1});
    for (int i = 0; i < 7; i++) wb(1'b1, ADR_ROM_BASE + 16'(48 + 4 * i), {20'h0, tail[i]});
    rd(ADR_ROM_BASE + 16'h0004, 32'h701);
    wb(1'b1, ADR_CTRL, 32'h1);
    step();
    fl(v);
    rd(ADR_GR_BASE, 32'(v));
    step();
    rd(ADR_GR_BASE + 16'h0004, 32'(v));
    g = v;
    for (int i = 0; i < 10; i++) begin
      step();
      e = alu(ops[i], sa, g);
      fl(e);
      chk(32'(PC_O), 32'(i + 3));
      if (ops[i] != OP_CPR) g = e;
      rd(ADR_GR_BASE + 16'h0004, 32'(g));
    end
    step();
    chk(32'({OUT_SEL_O, OUT_DATA_O}), 32'(g));
    repeat (4) step();
    rd(ADR_GR_BASE + 16'h0028, 32'(v));
    rd(ADR_GR_BASE + 16'h002C, 32'(v));
    chk(32'(n_out), 32'h1);
    step();
    fl(12'h000);
    step();
    chk(32'(PC_O), 32'h0);
    do_reset();
    tally_and_finish();
  end
endmodule : two_phase_micro_sequencer_tb_top
